// >>> verilog/sdo_params.svh
// constants for the stepper driver output block
// ==========================================================
// Overview of operation
// RL1 - config select bit 1 drives motors by step and direction outputs
// RL2 - select bit 0 runs serial driver mode sending sequencer datagrams
// RL3 - step/direction mode leaves sequencer and layout memory unused
// RL4 - step pulse lasts 16 times (1 plus low four divider bits) clocks
// RL5 - first step after a direction change waits one pulse length
// RL6 - step pulses never faster than system clock divided by 32
// RL7 - software picks a divider matching the fastest step rate used
// RL8 - serial clock period spans 16 to 512 system clocks
// RL9 - default serial clock is 16 low plus 16 high clocks
// RL10 - serial divider 7 gives minimum period, 8 low plus 8 high
// RL11 - chip select and serial clock polarities are programmable
// RL12 - last chip in the chain is motor driver 0
// RL13 - datagram layout comes from 32 addresses holding 64 entries
// RL14 - once set up, datagrams go out with no host action
// RL15 - each datagram carries between one and 64 bits
// RL16 - layout entry is five-bit selector plus next driver flag
// RL17 - entry with next driver flag set advances the driver counter
// RL18 - counter equal to last driver index ends datagram, counter cleared
// RL19 - chip select held for whole datagram, released between datagrams
// RL20 - direction changes only outside a step pulse, before delayed step
`ifndef SDO_PARAMS_SVH
`define SDO_PARAMS_SVH

// ==========================================================
// register map
`define SDO_ADDR_W 8
`define SDO_OFS_IF_CONFIG 8'h00
`define SDO_OFS_GLOBAL 8'h04
`define SDO_OFS_STATUS 8'h08
`define SDO_OFS_RX_DATA 8'h0C
`define SDO_OFS_LAYOUT 8'h80
`define SDO_LAYOUT_SEL_BIT 7

// ==========================================================
// fields
`define SDO_IF_STEPDIR_BIT 0
`define SDO_IF_CS_POL_BIT 1
`define SDO_IF_SCK_POL_BIT 2
`define SDO_IF_LAST_DRV_LSB 4
`define SDO_GLB_SCK_DIV_LSB 0
`define SDO_GLB_SECONDARY_CLOCK_DIVIDER_LSB 8
`define SDO_IF_CONFIG_RST 6'h00
`define SDO_SCK_DIV_RST 8'h0F
`define SDO_SECONDARY_CLOCK_DIVIDER_RST 8'h00

// ==========================================================
// timing
`define SDO_STEP_UNIT 9'h010
`define SDO_SCK_DIV_MIN 8'h07
`define SDO_MAX_ENTRY 6'h3F
`define SDO_AXES 3
`define SDO_SIG_PER_MOTOR 32

`endif

// >>> verilog/sdo_pkg.sv
// types for the stepper driver output block
package sdo_pkg;
    typedef enum logic [1:0] {SDO_AX_IDLE, SDO_AX_DELAY, SDO_AX_HIGH, SDO_AX_LOW} sdo_axis_t;
    typedef enum logic [2:0] {SDO_SR_IDLE, SDO_SR_SETUP, SDO_SR_LOW, SDO_SR_HIGH, SDO_SR_HOLD,
        SDO_SR_GAP} sdo_ser_t;
endpackage

// >>> verilog/sdo_top.sv
// stepper driver output interface: apb registers, step/dir engine, serial datagram engine
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "sdo_params.svh"

module sdo_top
    import sdo_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] step_req,
    input wire logic [2:0] step_dir,
    input wire logic [95:0] seq_signals,
    output logic [2:0] step_out,
    output logic [2:0] dir_out,
    output logic driver_serial_clk,
    output logic driver_serial_out,
    output logic driver_chip_select_n,
    input wire logic driver_serial_in
);

    // ==========================================================
    // configuration registers
    logic stepdir_select;
    logic cs_pol;
    logic sck_pol;
    logic [1:0] last_driver_index;
    logic [7:0] sck_div;
    logic [7:0] secondary_clock_divider;
    logic [11:0] layout_mem [0:31];
    logic [31:0] rx_data;
    logic [31:0] rx_shift;
    logic [1:0] drv_cnt;
    logic [5:0] entry_idx;
    sdo_ser_t ser_state;
    logic [2:0] ax_busy;

    wire logic [3:0] step_pulse_divider = secondary_clock_divider[3:0];
    wire logic apb_setup = psel & ~penable;
    wire logic apb_write = psel & penable & pready & pwrite;
    wire logic is_layout = paddr[`SDO_LAYOUT_SEL_BIT];
    wire logic [4:0] layout_word = paddr[6:2];

    // ==========================================================
    // apb slave: no wait state, yet every bus output is a flop
    // unmapped offsets answer with an error and never write
    logic addr_ok;
    logic [31:0] rd_mux;
    always_comb begin
        addr_ok = 1'b1;
        rd_mux = 32'h0000_0000;
        if (is_layout) begin
            rd_mux = {20'h00000, layout_mem[layout_word]};
        end else begin
            case (paddr)
                `SDO_OFS_IF_CONFIG: rd_mux = {26'h0000000, last_driver_index, 1'b0, sck_pol, cs_pol,
                    stepdir_select};
                `SDO_OFS_GLOBAL: rd_mux = {16'h0000, secondary_clock_divider, sck_div};
                `SDO_OFS_STATUS: rd_mux = {16'h0000, entry_idx, 1'b0, ser_state, ax_busy, 1'b0,
                    drv_cnt};
                `SDO_OFS_RX_DATA: rd_mux = rx_data;
                default: addr_ok = 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup & ~addr_ok;
            prdata <= (apb_setup & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stepdir_select <= 1'b0;
            cs_pol <= 1'b0;
            sck_pol <= 1'b0;
            last_driver_index <= 2'h0;
            sck_div <= `SDO_SCK_DIV_RST;
            secondary_clock_divider <= `SDO_SECONDARY_CLOCK_DIVIDER_RST;
        end else if (apb_write && !pslverr) begin
            if (paddr == `SDO_OFS_IF_CONFIG) begin
                stepdir_select <= pwdata[`SDO_IF_STEPDIR_BIT]; // RL1 RL2
                cs_pol <= pwdata[`SDO_IF_CS_POL_BIT];
                sck_pol <= pwdata[`SDO_IF_SCK_POL_BIT];
                last_driver_index <= pwdata[`SDO_IF_LAST_DRV_LSB +: 2];
            end
            if (paddr == `SDO_OFS_GLOBAL) begin
                sck_div <= pwdata[`SDO_GLB_SCK_DIV_LSB +: 8];
                secondary_clock_divider <= pwdata[`SDO_GLB_SECONDARY_CLOCK_DIVIDER_LSB +: 8];
            end
        end
    end

    // layout memory is data, not control, so it carries no reset
    always_ff @(posedge pclk) begin
        if (apb_write && !pslverr && is_layout) begin
            layout_mem[layout_word] <= pwdata[11:0]; // RL13
        end
    end

    // ==========================================================
    // step/direction engine, one copy per axis
    // pulse high L, then forced low L: period never below 2*16 clocks
    wire logic [8:0] pulse_len = `SDO_STEP_UNIT * {5'h00, step_pulse_divider} + `SDO_STEP_UNIT; // RL4

    genvar ax;
    generate
        for (ax = 0; ax < `SDO_AXES; ax = ax + 1) begin : g_axis
            sdo_axis_t st;
            logic [8:0] cnt;
            logic pend;
            logic pend_dir;
            wire logic take = pend | step_req[ax];
            wire logic want_dir = step_req[ax] ? step_dir[ax] : pend_dir;
            // one-deep pending request: later requests merge, latest direction wins

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pend <= 1'b0;
                    pend_dir <= 1'b0;
                end else if (step_req[ax] && st != SDO_AX_IDLE) begin
                    pend <= 1'b1;
                    pend_dir <= step_dir[ax];
                end else if (st == SDO_AX_IDLE) begin
                    pend <= 1'b0;
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    st <= SDO_AX_IDLE;
                    cnt <= 9'h000;
                    step_out[ax] <= 1'b0;
                    dir_out[ax] <= 1'b0;
                end else if (!stepdir_select) begin
                    st <= SDO_AX_IDLE; // RL3
                    cnt <= 9'h000;
                    step_out[ax] <= 1'b0;
                end else begin
                    case (st)
                        SDO_AX_IDLE: begin
                            if (take) begin
                                cnt <= pulse_len - 9'h001;
                                if (want_dir != dir_out[ax]) begin
                                    dir_out[ax] <= want_dir; // RL20
                                    st <= SDO_AX_DELAY; // RL5
                                end else begin
                                    step_out[ax] <= 1'b1;
                                    st <= SDO_AX_HIGH;
                                end
                            end
                        end
                        SDO_AX_DELAY: begin
                            if (cnt == 9'h000) begin
                                cnt <= pulse_len - 9'h001;
                                step_out[ax] <= 1'b1; // RL5
                                st <= SDO_AX_HIGH;
                            end else begin
                                cnt <= cnt - 9'h001;
                            end
                        end
                        SDO_AX_HIGH: begin
                            if (cnt == 9'h000) begin
                                cnt <= pulse_len - 9'h001;
                                step_out[ax] <= 1'b0; // RL4
                                st <= SDO_AX_LOW;
                            end else begin
                                cnt <= cnt - 9'h001;
                            end
                        end
                        // low as long as high, so the rate stays under clk/32
                        SDO_AX_LOW: begin
                            if (cnt == 9'h000) begin
                                st <= SDO_AX_IDLE; // RL6
                            end else begin
                                cnt <= cnt - 9'h001;
                            end
                        end
                        default: st <= SDO_AX_IDLE;
                    endcase
                end
            end

            assign ax_busy[ax] = (st != SDO_AX_IDLE);
        end
    endgenerate

    // ==========================================================
    // serial datagram engine
    // chain input is asynchronous: two flops before anything reads it
    logic sdi_meta;
    logic sdi_sync;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdi_meta <= 1'b0;
            sdi_sync <= 1'b0;
        end else begin
            sdi_meta <= driver_serial_in;
            sdi_sync <= sdi_meta;
        end
    end

    // half period of divider+1 clocks, clamped so the period stays within 16..512
    wire logic [7:0] half_m1 = (sck_div < `SDO_SCK_DIV_MIN) ? `SDO_SCK_DIV_MIN : sck_div; // RL8 RL9 RL10
    logic [7:0] half_cnt;
    wire logic half_done = (half_cnt == 8'h00);

    // current entry: even index in bits 5:0, odd in 11:6
    logic [11:0] cur_word;
    logic [5:0] cur_entry;
    logic cur_nxm;
    logic last_entry;
    logic [5:0] nxt_idx;
    logic [1:0] nxt_drv;
    logic [11:0] nxt_word;
    logic [5:0] nxt_entry;
    logic [6:0] bit_sel;
    logic nxt_bit;
    always_comb begin
        cur_word = layout_mem[entry_idx[5:1]];
        cur_entry = entry_idx[0] ? cur_word[11:6] : cur_word[5:0]; // RL16
        cur_nxm = cur_entry[5];
        last_entry = (cur_nxm && drv_cnt == last_driver_index) || entry_idx == `SDO_MAX_ENTRY; // RL15 RL18
        if (ser_state == SDO_SR_IDLE) begin
            nxt_idx = 6'h00;
            nxt_drv = 2'h0;
        end else begin
            nxt_idx = entry_idx + 6'h01;
            nxt_drv = cur_nxm ? drv_cnt + 2'h1 : drv_cnt; // RL17
        end
        nxt_word = layout_mem[nxt_idx[5:1]];
        nxt_entry = nxt_idx[0] ? nxt_word[11:6] : nxt_word[5:0];
        bit_sel = {nxt_drv, nxt_entry[4:0]}; // RL12
        nxt_bit = (nxt_drv == 2'h3) ? 1'b0 : seq_signals[bit_sel];
    end

    logic sck_high;
    logic cs_active;
    // outgoing bit, pinned in the same flop stage as clock and select
    logic sdo_bit;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ser_state <= SDO_SR_IDLE;
            half_cnt <= 8'h00;
            entry_idx <= 6'h00;
            drv_cnt <= 2'h0;
            sck_high <= 1'b0;
            cs_active <= 1'b0;
            sdo_bit <= 1'b0;
            rx_shift <= 32'h0000_0000;
            rx_data <= 32'h0000_0000;
        end else begin
            if (!half_done) begin
                half_cnt <= half_cnt - 8'h01;
            end
            case (ser_state)
                SDO_SR_IDLE: begin
                    if (!stepdir_select) begin
                        ser_state <= SDO_SR_SETUP; // RL2 RL14
                        half_cnt <= half_m1;
                        cs_active <= 1'b1; // RL19
                        entry_idx <= nxt_idx;
                        drv_cnt <= nxt_drv;
                        sdo_bit <= nxt_bit;
                    end
                end
                SDO_SR_SETUP: begin
                    if (half_done) begin
                        ser_state <= SDO_SR_HIGH;
                        half_cnt <= half_m1;
                        sck_high <= 1'b1;
                        rx_shift <= {rx_shift[30:0], sdi_sync};
                    end
                end
                SDO_SR_LOW: begin
                    if (half_done) begin
                        ser_state <= SDO_SR_HIGH;
                        half_cnt <= half_m1;
                        sck_high <= 1'b1;
                        rx_shift <= {rx_shift[30:0], sdi_sync};
                    end
                end
                SDO_SR_HIGH: begin
                    if (half_done) begin
                        half_cnt <= half_m1;
                        sck_high <= 1'b0;
                        if (last_entry) begin
                            ser_state <= SDO_SR_HOLD;
                            drv_cnt <= 2'h0; // RL18
                            entry_idx <= 6'h00;
                        end else begin
                            ser_state <= SDO_SR_LOW;
                            entry_idx <= nxt_idx;
                            drv_cnt <= nxt_drv; // RL17
                            sdo_bit <= nxt_bit;
                        end
                    end
                end
                SDO_SR_HOLD: begin
                    if (half_done) begin
                        ser_state <= SDO_SR_GAP;
                        half_cnt <= half_m1;
                        cs_active <= 1'b0; // RL19
                        rx_data <= rx_shift;
                    end
                end
                SDO_SR_GAP: begin
                    if (half_done) begin
                        ser_state <= SDO_SR_IDLE;
                    end
                end
                default: ser_state <= SDO_SR_IDLE;
            endcase
        end
    end

    // polarity applied in the output flop so pins stay glitch free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            driver_serial_clk <= 1'b0;
            driver_chip_select_n <= 1'b1;
            driver_serial_out <= 1'b0;
        end else begin
            // data shares the clock's delay so it never moves while the pin clock is in its active phase
            driver_serial_out <= sdo_bit;
            driver_serial_clk <= sck_high ^ sck_pol; // RL11
            driver_chip_select_n <= ~cs_active ^ cs_pol; // RL11
        end
    end

endmodule

// >>> bench/sdo_drv_model.sv
// model of the serial driver chain on the far side of the block
`timescale 1ns/1ps
module sdo_drv_model (
    input wire logic pclk,
    input wire logic sck_act,
    input wire logic sdo,
    input wire logic cs_act,
    output logic sdi
);
    // ========
    // chain of shift registers
    logic [63:0] chain = 64'h0;
    logic sck_q = 1'b0;
    always @(posedge pclk) begin
        sck_q <= sck_act;
        if (cs_act && sck_act && !sck_q) begin
            chain <= {chain[62:0], sdo};
        end
    end
    // pull-up holds the line while the chain is deselected
    assign sdi = cs_act ? chain[63] : 1'b1;
endmodule

// >>> bench/sdo_top_assertions.sv
// checker for the stepper driver output block
`timescale 1ns/1ps
module sdo_top_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [2:0] step_out,
    input wire logic [2:0] dir_out,
    input wire logic driver_serial_clk,
    input wire logic driver_serial_out,
    input wire logic driver_chip_select_n
);
    // ========
    // snooped config; serial checks wait out a quiet time after writes
    logic wr, sd, csp, ckp, quiet, sck_a, cs_a;
    logic [3:0] sdiv;
    logic [7:0] cdiv;
    logic [8:0] slen, hh, hi_n, lo_n, dn, ch;
    logic [12:0] qt;
    assign wr = psel && penable && pready && pwrite;
    assign slen = {sdiv + 5'h01, 4'h0};
    assign hh = (cdiv < 8'h07 ? 9'h007 : {1'b0, cdiv}) + 9'h001;
    assign quiet = qt[12];
    assign sck_a = driver_serial_clk ^ ckp;
    assign cs_a = driver_chip_select_n == csp;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {sd, csp, ckp} <= 3'h0;
            sdiv <= 4'h0;
            cdiv <= 8'h0F;
        end else if (wr && paddr == 8'h00) begin
            {ckp, csp, sd} <= pwdata[2:0];
        end else if (wr && paddr == 8'h04) begin
            {sdiv, cdiv} <= pwdata[11:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qt <= 13'h0000;
            {hi_n, lo_n, dn, ch} <= 36'h0;
        end else begin
            qt <= wr ? 13'h0000 : qt + {12'h000, !quiet};
            hi_n <= step_out[0] ? hi_n + 9'h001 : 9'h000;
            lo_n <= step_out[0] ? 9'h000 : lo_n + {8'h00, lo_n != 9'h1FF};
            dn <= (dir_out[0] != $past(dir_out[0])) ? 9'h001 : dn + {8'h00, dn != 9'h1FF};
            ch <= sck_a ? ch + 9'h001 : 9'h000;
        end
    end
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence one_cycle_ready;
        pready ##1 !pready;
    endsequence
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    apb_ready_a: assert property (apb_setup |=> one_cycle_ready)
        else $error("apb access not answered in one cycle");
    step_width_a: assert property ($fell(step_out[0]) |-> hi_n == slen)
        else $error("step pulse length wrong");
    dir_delay_a: assert property ($rose(step_out[0]) |-> dn >= slen)
        else $error("step too soon after direction change");
    step_gap_a: assert property ($rose(step_out[0]) |-> lo_n >= slen)
        else $error("step pulses too close");
    dir_hold_a: assert property ($changed(dir_out) |->
        ((dir_out ^ $past(dir_out)) & (step_out | $past(step_out))) == 3'h0)
        else $error("direction changed inside a step pulse");
    serial_nostep_a: assert property (!sd |-> step_out == 3'h0)
        else $error("step pulse in serial mode");
    step_nochain_a: assert property (sd && quiet |-> !cs_a)
        else $error("datagram sent in step mode");
    sck_high_a: assert property (quiet && $fell(sck_a) |-> ch == hh)
        else $error("serial clock high phase wrong");
    sck_framed_a: assert property (quiet && !cs_a |-> !sck_a)
        else $error("serial clock active outside a datagram");
    sdo_hold_a: assert property (quiet && sck_a |-> $stable(driver_serial_out))
        else $error("serial data moved while clock high");
endmodule
bind sdo_top sdo_top_assertions u_chk (.*);

// >>> bench/sdo_top_test.sv
// self-checking bench for the stepper driver output block
`timescale 1ns/1ps
module sdo_top_test;
    // ========
    // bench signals and tasks
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, csp = 1'b0, ckp = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, driver_serial_clk, driver_serial_out, driver_chip_select_n, driver_serial_in, cs_act;
    logic [2:0] step_req = 3'h0, step_dir = 3'h0, step_out, dir_out;
    logic [95:0] seq_signals = 96'h0;
    logic [11:0] lay [32];
    int n_errors = 0, compares = 0, n, ax, dv, L, i;
    logic d;
    bit q[$];
    always #50 pclk = ~pclk;
    assign cs_act = driver_chip_select_n == csp;
    sdo_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .step_req(step_req), .step_dir(step_dir), .seq_signals(seq_signals), .step_out(step_out),
        .dir_out(dir_out), .driver_serial_clk(driver_serial_clk), .driver_serial_out(driver_serial_out),
        .driver_chip_select_n(driver_chip_select_n), .driver_serial_in(driver_serial_in));
    sdo_drv_model u_drv (.pclk(pclk), .sck_act(driver_serial_clk ^ ckp), .sdo(driver_serial_out),
        .cs_act(cs_act), .sdi(driver_serial_in));
    task automatic finish_test;
        $display("compares=%0d errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tmo(input int k, input int lim);
        if (k >= lim) begin
            n_errors++;
            finish_test();
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 100 && pready !== 1'b1; k++) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        tmo(k, 100);
        @(posedge pclk);
    endtask
    task automatic pulse(input int a, input logic dr);
        step_req[a] <= 1'b1;
        step_dir[a] <= dr;
        @(posedge pclk);
        step_req[a] <= 1'b0;
    endtask
    task automatic count(input int a, input logic lvl, output int k);
        for (k = 1; k < 3000 && step_out[a] !== lvl; k++) @(posedge pclk);
        tmo(k, 3000);
    endtask
    task automatic wait_cs(input logic lvl);
        int k;
        for (k = 0; k < 40000 && cs_act !== lvl; k++) @(posedge pclk);
        tmo(k, 40000);
    endtask
    task automatic serial_run(input logic [7:0] cdiv, input logic [1:0] pol);
        logic [1:0] last;
        logic [5:0] ent;
        logic a, prev;
        logic got[$];
        int drv, e, hc, hl;
        last = 2'($urandom_range(3));
        apb(1'b1, 8'h04, {24'h0, cdiv});
        apb(1'b1, 8'h00, {26'h0, last, 1'b0, pol, 1'b0});
        csp = pol[0];
        ckp = pol[1];
        q.delete();
        drv = 0;
        for (e = 0; e < 64; e++) begin
            ent = lay[e / 2][6 * (e % 2) +: 6];
            q.push_back(drv < 3 ? seq_signals[drv * 32 + ent[4:0]] : 1'b0);
            if (ent[5] && drv == last) break;
            if (ent[5]) drv++;
        end
        pulse(0, 1'b1);
        repeat (4500) @(posedge pclk);
        wait_cs(1'b0);
        wait_cs(1'b1);
        prev = 1'b0;
        hc = 0;
        hl = 0;
        for (i = 0; i < 40000 && cs_act === 1'b1; i++) begin
            a = driver_serial_clk ^ ckp;
            if (a && !prev) got.push_back(driver_serial_out);
            if (!a && prev) hl = hc;
            hc = a ? hc + 1 : 0;
            prev = a;
            @(posedge pclk);
        end
        tmo(i, 40000);
        check(got.size(), q.size());
        for (e = 0; e < q.size() && e < got.size(); e++) check({31'h0, got[e]}, {31'h0, q[e]});
        check(hl, cdiv < 8'h07 ? 8 : cdiv + 1);
        check({29'h0, step_out}, 32'h0);
    endtask
    // ========
    // main sequence
    initial begin
        void'($urandom(32'hD59C6F22));
        seq_signals <= {$urandom, $urandom, $urandom};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h04, 32'h0);
        check(rd, 32'h0000000F);
        apb(1'b0, 8'h10, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
        for (i = 0; i < 32; i++) begin
            lay[i] = 12'($urandom);
            apb(1'b1, 8'h80 | 8'(i << 2), {20'h0, lay[i]});
            apb(1'b0, 8'h80 | 8'(i << 2), 32'h0);
            check(rd, {20'h0, lay[i]});
        end
        serial_run(8'h0F, 2'h0);
        serial_run(8'h07, 2'h3);
        serial_run(8'h03, 2'h1);
        apb(1'b1, 8'h00, 32'h00000001);
        csp = 1'b0;
        ckp = 1'b0;
        repeat (4500) @(posedge pclk);
        for (ax = 0; ax < 3; ax++) begin
            dv = $urandom_range(3);
            L = 16 * (dv + 1);
            apb(1'b1, 8'h04, {20'h0, 4'(dv), 8'h0F});
            d = ~dir_out[ax];
            pulse(ax, d);
            count(ax, 1'b1, n);
            check(n, L + 2);
            check({31'h0, dir_out[ax]}, {31'h0, d});
            pulse(ax, d);
            count(ax, 1'b0, n);
            check(n, L);
            count(ax, 1'b1, n);
            check(n, L + 2);
            count(ax, 1'b0, n);
            check(n, L + 1);
            repeat (L) @(posedge pclk);
            pulse(ax, d);
            count(ax, 1'b1, n);
            check(n, 2);
            count(ax, 1'b0, n);
        end
        repeat (4500) @(posedge pclk);
        finish_test();
    end
endmodule
